// [logic/cascade_pkg.sv]
// constants, field layout and types shared by the cascaded event/pwm counter
package cascade_pkg;

    // ------------------------------------------------------------------
    // register byte offsets on the apb bus
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LOWER_CTRL = 8'h00;  // lower_timer_control
    localparam logic [7:0] ADDR_UPPER_CTRL = 8'h04;  // upper_timer_control
    localparam logic [7:0] ADDR_PERIOD_LO  = 8'h08;  // period_compare_low
    localparam logic [7:0] ADDR_PERIOD_HI  = 8'h0c;  // period_compare_high
    localparam logic [7:0] ADDR_DUTY_LO    = 8'h10;  // duty_compare_low
    localparam logic [7:0] ADDR_DUTY_HI    = 8'h14;  // duty_compare_high
    localparam logic [7:0] ADDR_COUNT      = 8'h18;  // live 16-bit count, read only
    localparam logic [7:0] ADDR_OPTION     = 8'h1c;  // divider option

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int UC_INIT_BIT   = 7;  // flop_initial_value_bit
    localparam int UC_START_BIT  = 3;  // upper_start_bit
    localparam int MODE_LSB      = 0;  // mode field, three bits, in both controls
    localparam int LC_CLKSEL_LSB = 4;  // source clock select, three bits
    localparam int OPT_DIV_BIT   = 0;  // divider_option_bit

    // ------------------------------------------------------------------
    // mode codes of the mode field
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_EVENT = 3'h3;  // 16-bit event counter
    localparam logic [2:0] MODE_PWM   = 3'h6;  // 16-bit pwm output

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic        FLOP_RST  = 1'b0;   // output flop clears on reset
    localparam logic        PIN_RST   = 1'b1;   // pin is the inverse of the flop
    localparam logic [10:0] DIV_RST   = 11'h000;
    localparam logic [2:0]  FSDIV_RST = 3'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int PCLK_PERIOD_NS = 8;  // machine clock fc is pclk, 125 MHz

    // source clock select codes
    typedef enum logic [2:0] {
        CLK_SLOWEST = 3'h0,  // fc/2^11, or fs/2^3 with the divider option set
        CLK_DIV7    = 3'h1,  // fc/2^7
        CLK_DIV5    = 3'h2,  // fc/2^5
        CLK_DIV3    = 3'h3,  // fc/2^3
        CLK_FS      = 3'h4,  // fs
        CLK_DIV1    = 3'h5,  // fc/2
        CLK_FC      = 3'h6,  // fc
        CLK_EXT     = 3'h7   // falling edge of the event input
    } clk_sel_t;

    // apb slave states, gray along idle -> respond -> idle
    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_RESP = 1'b1
    } apb_state_t;

endpackage

// [logic/edge_sync.sv]
// two-flop synchroniser with edge detection for an asynchronous pin
`timescale 1ns/10ps
module edge_sync
    import cascade_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_async,
    output logic      rise,
    output logic      fall
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic s1;    // first stage, seen only by s2
        logic s2;    // safe sample
        logic prev;  // previous safe sample
    } sync_t;

    sync_t s_q;  // registered state
    sync_t s_d;  // next state

    // shift the pin through the stages
    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin_async;
        s_d.s2   = s_q.s1;
        s_d.prev = s_q.s2;
    end

    // edges come from two safe samples only, never from s1
    assign fall = s_q.prev & ~s_q.s2;
    assign rise = ~s_q.prev & s_q.s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// [logic/source_prescaler.sv]
// prescaler that turns pclk, fs and the event input into one count tick
`timescale 1ns/10ps
module source_prescaler
    import cascade_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire clk_sel_t   sel,
    input  wire logic       div_option,
    input  wire logic       fs_rise,
    input  wire logic       ext_fall,
    output logic            tick
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [10:0] div;    // free divider of fc
        logic [2:0]  fsdiv;  // divider of fs
    } pre_t;

    pre_t s_q;  // registered state
    pre_t s_d;  // next state

    // the dividers run free, so a tick lands at most one period after start
    always_comb begin
        s_d       = s_q;
        s_d.div   = s_q.div + 11'h001;
        s_d.fsdiv = fs_rise ? s_q.fsdiv + 3'h1 : s_q.fsdiv;
    end

    // pick the source, one pulse per source period
    always_comb begin
        case (sel)
            CLK_SLOWEST: tick = div_option ? (fs_rise && s_q.fsdiv == 3'h7)
                                           : (s_q.div == 11'h7ff);
            CLK_DIV7:    tick = (s_q.div[6:0] == 7'h7f);
            CLK_DIV5:    tick = (s_q.div[4:0] == 5'h1f);
            CLK_DIV3:    tick = (s_q.div[2:0] == 3'h7);
            CLK_FS:      tick = fs_rise;
            CLK_DIV1:    tick = s_q.div[0];
            CLK_FC:      tick = 1'b1;
            CLK_EXT:     tick = ext_fall;
            default:     tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{div: DIV_RST, fsdiv: FSDIV_RST};
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// [logic/cascaded_event_pwm_counter.sv]
// cascaded 16-bit event counter and pwm generator with an apb register file
`timescale 1ns/10ps
module cascaded_event_pwm_counter
    import cascade_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_input_pin,
    input  wire logic        slow_clock_pin,
    output logic             pwm_output_pin,
    output logic             cascade_timer_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        apb_state_t  apb;        // bus handshake phase
        logic        ready;      // pready
        logic [31:0] rdata;      // prdata
        logic        slverr;     // pslverr
        logic [7:0]  lctrl;      // lower_timer_control
        logic [7:0]  uctrl;      // upper_timer_control
        logic        divopt;     // divider_option_bit
        logic [15:0] period;     // period_compare, live
        logic [15:0] duty_hold;  // duty_compare holding stage
        logic [15:0] duty_act;   // duty_compare in use
        logic [15:0] cnt;        // cascaded up-counter
        logic        dload;      // duty written while stopped
        logic        tff;        // output flop
        logic        pin;        // pwm_output_pin
        logic        irq;        // cascade_timer_irq pulse
    } state_t;

    state_t s_q;  // registered state
    state_t s_d;  // next state

    logic ext_fall;  // synchronised falling edge of the event input
    logic fs_rise;   // synchronised rising edge of the slow clock
    logic src_tick;  // selected source tick
    logic running;   // upper start bit
    logic evt_mode;  // event counter selected
    logic pwm_mode;  // pwm selected
    logic tick;      // count enable this cycle

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // 17-bit increment so the pwm overflow is visible
    function automatic logic [16:0] inc16(input logic [15:0] v);
        inc16 = {1'b0, v} + 17'h00001;
    endfunction

    // replace one byte of a 16-bit compare
    function automatic logic [15:0] set_byte(input logic [15:0] w, input logic hi,
                                             input logic [7:0] b);
        set_byte = hi ? {b, w[7:0]} : {w[15:8], b};
    endfunction

    // decode of the register map
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            ADDR_LOWER_CTRL, ADDR_UPPER_CTRL, ADDR_PERIOD_LO, ADDR_PERIOD_HI,
            ADDR_DUTY_LO, ADDR_DUTY_HI, ADDR_COUNT, ADDR_OPTION: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers and source selection
    // ------------------------------------------------------------------
    edge_sync u_event_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (event_input_pin),
        .rise      (),
        .fall      (ext_fall)
    );

    edge_sync u_slow_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (slow_clock_pin),
        .rise      (fs_rise),
        .fall      ()
    );

    source_prescaler u_prescaler (
        .pclk       (pclk),
        .presetn    (presetn),
        .sel        (clk_sel_t'(s_q.lctrl[LC_CLKSEL_LSB +: 3])),
        .div_option (s_q.divopt),
        .fs_rise    (fs_rise),
        .ext_fall   (ext_fall),
        .tick       (src_tick)
    );

    // mode decode; both controls must agree to cascade
    assign running  = s_q.uctrl[UC_START_BIT];
    assign evt_mode = (s_q.uctrl[MODE_LSB +: 3] == MODE_EVENT) &&
                      (s_q.lctrl[MODE_LSB +: 3] == MODE_EVENT);
    assign pwm_mode = (s_q.uctrl[MODE_LSB +: 3] == MODE_PWM) &&
                      (s_q.lctrl[MODE_LSB +: 3] == MODE_PWM);
    // event mode always counts the pin; pwm takes the selected source
    assign tick     = evt_mode ? ext_fall : src_tick;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [16:0] nxt;
        nxt       = inc16(s_q.cnt);
        s_d       = s_q;
        s_d.irq   = 1'b0;
        s_d.dload = 1'b0;

        // counting; the period compare is read live, so a rewrite acts at once
        if (running && tick) begin
            if (evt_mode) begin
                if (nxt[15:0] == s_q.period) begin
                    s_d.cnt = WORD_RST;
                    s_d.irq = 1'b1;
                end else begin
                    s_d.cnt = nxt[15:0];
                end
            end else if (pwm_mode) begin
                if (nxt[16]) begin
                    // full wrap only: period is 65536 ticks
                    s_d.cnt      = WORD_RST;
                    s_d.tff      = ~s_q.tff;
                    s_d.irq      = 1'b1;
                    s_d.duty_act = s_q.duty_hold;
                end else begin
                    s_d.cnt = nxt[15:0];
                    if (nxt[15:0] == s_q.duty_act) begin
                        s_d.tff = ~s_q.tff;
                    end
                end
            end
        end

        // a duty written while stopped is shifted in the next cycle
        if (s_q.dload && !running) begin
            s_d.duty_act = s_q.duty_hold;
        end

        // apb slave: one wait cycle, then the response
        case (s_q.apb)
            APB_IDLE: begin
                if (psel && penable) begin
                    s_d.apb    = APB_RESP;
                    s_d.ready  = 1'b1;
                    s_d.slverr = ~is_mapped(paddr);
                    case (paddr)
                        ADDR_LOWER_CTRL: s_d.rdata = {24'h000000, s_q.lctrl};
                        ADDR_UPPER_CTRL: s_d.rdata = {24'h000000, s_q.uctrl};
                        ADDR_PERIOD_LO:  s_d.rdata = {24'h000000, s_q.period[7:0]};
                        ADDR_PERIOD_HI:  s_d.rdata = {24'h000000, s_q.period[15:8]};
                        // running pwm shows the value in use, not the latest write
                        ADDR_DUTY_LO:    s_d.rdata = (pwm_mode && running) ?
                                             {24'h000000, s_q.duty_act[7:0]} :
                                             {24'h000000, s_q.duty_hold[7:0]};
                        ADDR_DUTY_HI:    s_d.rdata = (pwm_mode && running) ?
                                             {24'h000000, s_q.duty_act[15:8]} :
                                             {24'h000000, s_q.duty_hold[15:8]};
                        ADDR_COUNT:      s_d.rdata = {16'h0000, s_q.cnt};
                        ADDR_OPTION:     s_d.rdata = {31'h00000000, s_q.divopt};
                        default:         s_d.rdata = 32'h00000000;
                    endcase
                end
            end
            APB_RESP: begin
                s_d.apb   = APB_IDLE;
                s_d.ready = 1'b0;
                // the write takes effect at the edge that samples pready
                if (psel && penable && pwrite && is_mapped(paddr)) begin
                    case (paddr)
                        ADDR_LOWER_CTRL: s_d.lctrl = pwdata[7:0];
                        ADDR_UPPER_CTRL: begin
                            s_d.uctrl = pwdata[7:0];
                            // a stopped timer takes the initial level; a running one
                            // keeps its level when stopped
                            if (!running) begin
                                s_d.tff = pwdata[UC_INIT_BIT];
                                if (pwdata[UC_START_BIT]) begin
                                    s_d.cnt = WORD_RST;
                                end
                            end
                        end
                        ADDR_PERIOD_LO:  s_d.period = set_byte(s_q.period, 1'b0,
                                                               pwdata[7:0]);
                        ADDR_PERIOD_HI:  s_d.period = set_byte(s_q.period, 1'b1,
                                                               pwdata[7:0]);
                        ADDR_DUTY_LO: begin
                            s_d.duty_hold = set_byte(s_q.duty_hold, 1'b0, pwdata[7:0]);
                            s_d.dload     = ~running;
                        end
                        ADDR_DUTY_HI: begin
                            s_d.duty_hold = set_byte(s_q.duty_hold, 1'b1, pwdata[7:0]);
                            s_d.dload     = ~running;
                        end
                        ADDR_OPTION:     s_d.divopt = pwdata[OPT_DIV_BIT];
                        default:         s_d.divopt = s_q.divopt;
                    endcase
                end
            end
            default: s_d.apb = APB_IDLE;
        endcase

        // the pin is the flop inverted, registered alongside it
        s_d.pin = ~s_d.tff;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{apb: APB_IDLE, ready: 1'b0, rdata: 32'h00000000, slverr: 1'b0,
                     lctrl: CTRL_RST, uctrl: CTRL_RST, divopt: 1'b0,
                     period: WORD_RST, duty_hold: WORD_RST, duty_act: WORD_RST,
                     cnt: WORD_RST, dload: 1'b0, tff: FLOP_RST,
                     pin: PIN_RST, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata            = s_q.rdata;
    assign pready            = s_q.ready;
    assign pslverr           = s_q.slverr;
    assign pwm_output_pin    = s_q.pin;
    assign cascade_timer_irq = s_q.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence duty_write_stopped;
        s_q.apb == APB_RESP && psel && penable && pwrite && !running &&
        (paddr == ADDR_DUTY_LO || paddr == ADDR_DUTY_HI);
    endsequence

    sequence shifted_in;
        ##2 (s_q.duty_act == $past(s_q.duty_hold));
    endsequence

    AST_PIN_INVERSE: assert property (pwm_output_pin == ~s_q.tff)
        else $error("pwm pin is not the inverse of the flop");

    AST_EVT_MATCH: assert property (running && evt_mode && tick &&
        inc16(s_q.cnt) == {1'b0, s_q.period} |=> s_q.cnt == 16'h0000 && cascade_timer_irq)
        else $error("event match did not clear and interrupt");

    AST_EVT_COUNT: assert property (running && evt_mode && ext_fall &&
        inc16(s_q.cnt) != {1'b0, s_q.period} |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("event edge did not advance the count");

    AST_PWM_DUTY: assert property (running && pwm_mode && tick && s_q.cnt != 16'hffff &&
        s_q.cnt + 16'h0001 == s_q.duty_act |=> s_q.tff != $past(s_q.tff) && s_q.cnt != 16'h0000)
        else $error("duty match did not invert the flop");

    AST_PWM_OVF: assert property (running && pwm_mode && tick && s_q.cnt == 16'hffff
        |=> s_q.cnt == 16'h0000 && cascade_timer_irq && s_q.tff != $past(s_q.tff))
        else $error("overflow did not clear, invert and interrupt");

    AST_DUTY_AT_IRQ: assert property (cascade_timer_irq && pwm_mode
        |-> s_q.duty_act == $past(s_q.duty_hold))
        else $error("duty not shifted at the interrupt");

    AST_DUTY_STOPPED: assert property (duty_write_stopped ##1 !running
        |-> shifted_in)
        else $error("duty not shifted after a write while stopped");

    AST_STOP_HOLD: assert property (!running && !(s_q.apb == APB_RESP && psel && penable &&
        pwrite && paddr == ADDR_UPPER_CTRL) |=> s_q.tff == $past(s_q.tff))
        else $error("flop changed while stopped without a control write");

    AST_INIT_LOAD: assert property (s_q.apb == APB_RESP && psel && penable && pwrite &&
        paddr == ADDR_UPPER_CTRL && !running |=> s_q.tff == s_q.uctrl[UC_INIT_BIT])
        else $error("flop did not take the initial level");

    AST_PWM_NO_MATCH_IRQ: assert property (running && pwm_mode && tick &&
        s_q.cnt != 16'hffff |=> !cascade_timer_irq && s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("pwm cleared before a full wrap");

    // edges reach the count only through the synchroniser, two edges on
    AST_EVT_SYNC: assert property ($fell(event_input_pin) |-> ##2 ext_fall)
        else $error("pin fall did not become one safe edge");

    AST_EVT_HOLD: assert property (running && evt_mode && !ext_fall
        |=> s_q.cnt == $past(s_q.cnt))
        else $error("event count moved without an edge");

    AST_IRQ_RUNNING: assert property (cascade_timer_irq |-> $past(running))
        else $error("interrupt raised while stopped");

    // a period byte is live one edge after the write, with no holding stage
    sequence period_lo_write;
        s_q.apb == APB_RESP && psel && penable && pwrite && paddr == ADDR_PERIOD_LO;
    endsequence

    AST_PERIOD_AT_ONCE: assert property (period_lo_write
        |=> s_q.period[7:0] == $past(pwdata[7:0]))
        else $error("period byte did not take effect at once");

    AST_DUTY_READ: assert property (s_q.apb == APB_IDLE && psel && penable &&
        !pwrite && paddr == ADDR_DUTY_LO && pwm_mode && running
        |=> prdata[7:0] == $past(s_q.duty_act[7:0]))
        else $error("running duty read did not show the value in use");

endmodule

// [testbench/event_pulse_source.sv]
// far-side model: event pulse source and free-running slow clock
`timescale 1ns/10ps
module event_pulse_source (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [7:0] burst,
    output logic            event_pin,
    output logic            fs_pin,
    output logic            busy
);
    logic [2:0] fs_div = 3'h0;  // slow oscillator runs free at pclk/8
    assign fs_pin = fs_div[2];
    always @(posedge pclk) begin
        fs_div <= fs_div + 3'h1;
    end
    // bursts of falling edges; four cycles per level keeps clear of the sync minimum
    initial begin
        event_pin = 1'b1;
        busy      = 1'b0;
        forever begin
            @(posedge pclk);
            if (go) begin
                busy <= 1'b1;
                repeat (burst) begin
                    event_pin <= 1'b0;
                    repeat (4) @(posedge pclk);
                    event_pin <= 1'b1;
                    repeat (4) @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// [testbench/cascaded_event_pwm_counter_test.sv]
// self-checking bench for the cascaded event and pwm counter
`timescale 1ns/10ps
module cascaded_event_pwm_counter_test import cascade_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, go, pready, pslverr;
    logic        ev, fs, pwm, irq, busy, err;
    logic [7:0]  paddr, burst;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt = 0, checked = 0, cyc = 0, irq_cnt = 0, irq_cyc = 0;
    int          seed = 55792, t0, n, tot, d, d2, base;
    // pwm is read straight off the pin, as with the port latch set to one
    cascaded_event_pwm_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input_pin(ev),
        .slow_clock_pin(fs), .pwm_output_pin(pwm), .cascade_timer_irq(irq));
    event_pulse_source src (.pclk(pclk), .go(go), .burst(burst), .event_pin(ev),
        .fs_pin(fs), .busy(busy));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // edge count and interrupt log; the pulse lasts one cycle so it is caught here
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            irq_cyc <= cyc;
        end
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_pin(input int c, input logic exp);
        repeat (c) @(posedge pclk);
        check({31'h0, pwm}, {31'h0, exp});
    endtask
    task automatic send(input logic [7:0] cnt);
        int k;
        @(posedge pclk);
        burst <= cnt;
        go    <= 1'b1;
        @(posedge pclk);
        go    <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (busy !== 1'b0 && k < 4000);
        repeat (8) @(posedge pclk);  // room for the input synchroniser
    endtask
    // expected count left over, or interrupts raised, after e edges with period p
    function automatic logic [31:0] evt_exp(input int e, input int p, input logic irqs);
        evt_exp = irqs ? 32'(e / p) : 32'(e % p);
    endfunction
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    // ------------------------------------------------------------------
    // main sequence: reset, refusal, event counting, pwm
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, go, paddr, pwdata, burst} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_pin(1, 1'b1);
        apb(1'b0, 8'h20, 8'h00);
        check({31'h0, err}, 32'h1);  // unmapped place refused
        check(rd, 32'h0);  // refused read gives zero
        apb(1'b1, ADDR_LOWER_CTRL, 8'h73);  // external edges, event mode
        apb(1'b1, ADDR_PERIOD_LO, 8'h03);
        apb(1'b1, ADDR_PERIOD_HI, 8'h00);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h03);  // initial bit stays zero
        apb(1'b1, ADDR_UPPER_CTRL, 8'h0b);
        tot = 0;
        for (int i = 0; i < 4; i++) begin
            n = 1 + {$random(seed)} % 5;
            send(n[7:0]);
            tot += n;
            apb(1'b0, ADDR_COUNT, 8'h00);
            check(rd, evt_exp(tot, 3, 1'b0));
            check(32'(irq_cnt), evt_exp(tot, 3, 1'b1));
        end
        d  = 8 + {$random(seed)} % 200;
        d2 = 8 + {$random(seed)} % 200;
        apb(1'b1, ADDR_UPPER_CTRL, 8'h06);  // stop before the mode change
        apb(1'b1, ADDR_LOWER_CTRL, 8'h66);  // fc source, pwm mode
        apb(1'b1, ADDR_DUTY_LO, d[7:0]);
        apb(1'b1, ADDR_DUTY_HI, 8'h00);
        apb(1'b0, ADDR_DUTY_LO, 8'h00);
        check(rd, 32'(d));
        apb(1'b1, ADDR_UPPER_CTRL, 8'h86);
        wait_pin(2, 1'b0);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h06);
        wait_pin(2, 1'b1);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h0e);
        t0 = cyc;
        base = irq_cnt;
        apb(1'b1, ADDR_DUTY_LO, d2[7:0]);
        apb(1'b1, ADDR_DUTY_HI, 8'h00);
        apb(1'b0, ADDR_DUTY_LO, 8'h00);
        check(rd, 32'(d));
        wait_pin(220, 1'b0);
        for (n = 0; irq_cnt == base && n < 70000; n++) @(posedge pclk);
        check({31'h0, (irq_cyc - t0) inside {[65536:65538]}}, 32'h1);
        wait_pin(2, 1'b1);
        apb(1'b0, ADDR_DUTY_LO, 8'h00);
        check(rd, 32'(d2));
        wait_pin(220, 1'b0);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h06);
        wait_pin(8, 1'b0);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h06);
        wait_pin(2, 1'b1);
        apb(1'b1, ADDR_LOWER_CTRL, 8'h36);  // fc/2^3 source, pwm mode
        apb(1'b1, ADDR_UPPER_CTRL, 8'h0e);
        repeat (80) @(posedge pclk);
        apb(1'b0, ADDR_COUNT, 8'h00);
        // 82 edges from start to the read sample, one tick per 8 cycles
        check({31'h0, rd inside {[10:11]}}, 32'h1);
        apb(1'b1, ADDR_UPPER_CTRL, 8'h06);  // stopped before any low-power entry
        report_and_stop();
    end
endmodule
